// ==== mmd_agu.sv ====
`timescale 1ns/10ps
module mmd_agu
   import mmd_pkg::*;
#(
   parameter bit ALLOW_BITREV = 1'b1
) (
   input wire logic [15:0] ptr,
   input wire logic byte_op,
   input wire mmd_amode_t mode,
   input wire logic [15:0] mod_start,
   input wire logic [15:0] mod_end,
   input wire logic [15:0] rev_mod,
   output logic [15:0] next_ptr
);
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction

   logic [15:0] step;
   logic [15:0] inc;

   assign step = byte_op ? INC_BYTE : INC_WORD;
   assign inc = ptr + step;

   always_comb begin
      next_ptr = ptr;
      unique case (mode)
         AM_PLAIN: next_ptr = ptr;
         AM_POSTINC: next_ptr = inc;
         AM_POSTDEC: next_ptr = ptr - step;
         // wrap back to the buffer start once the end is passed
         AM_MODULO: next_ptr = (inc > mod_end) ? mod_start : inc;
         AM_BITREV: begin
            // reverse-carry add; read generators fall back to plain increment
            if (ALLOW_BITREV) begin
               next_ptr = rev16(rev16(ptr) + rev16(rev_mod));
            end else begin
               next_ptr = inc;
            end
         end
      endcase
   end
endmodule

// ==== mmd_core.sv ====
`timescale 1ns/10ps
module mmd_core
   import mmd_pkg::*;
#(
   parameter int RAM_WORDS = RAM_WORDS_DEF,
   parameter int SFR_WORDS = SFR_WORDS_DEF,
   parameter logic [15:0] Y_BASE = Y_BASE_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   input wire mmd_pcop_t pc_op,
   input wire logic [23:0] pc_target,
   input wire logic [15:0] pm_lo_word,
   input wire logic [15:0] pm_hi_word,
   input wire logic vec_req,
   input wire logic vec_alt,
   input wire logic [6:0] vec_num,
   output logic [23:0] pc,
   output logic [23:0] instr_word,
   output logic pc_in_vectors,
   output logic [23:0] vec_addr,
   output logic vec_valid,
   input wire logic xr_valid,
   input wire logic xr_byte,
   input wire mmd_src_t xr_src,
   input wire mmd_amode_t xr_mode,
   input wire logic [15:0] xr_ptr,
   input wire logic [15:0] xr_direct,
   input wire logic [12:0] xr_near,
   input wire logic yr_valid,
   input wire mmd_amode_t yr_mode,
   input wire logic [15:0] yr_ptr,
   input wire logic xw_valid,
   input wire logic xw_byte,
   input wire mmd_src_t xw_src,
   input wire mmd_amode_t xw_mode,
   input wire logic [15:0] xw_ptr,
   input wire logic [15:0] xw_direct,
   input wire logic [12:0] xw_near,
   input wire logic [15:0] xw_data,
   input wire logic [15:0] mod_start,
   input wire logic [15:0] mod_end,
   input wire logic [15:0] rev_mod,
   input wire mmd_wop_t w_op,
   input wire logic [3:0] w_sel,
   input wire logic [7:0] w_byte,
   output logic [15:0] xr_rdata,
   output logic xr_rvalid,
   output logic [15:0] yr_rdata,
   output logic yr_rvalid,
   output logic [15:0] xr_next_ptr,
   output logic [15:0] yr_next_ptr,
   output logic [15:0] xw_next_ptr,
   output logic xr_psv,
   output logic [15:0] psv_ea,
   output logic addr_error,
   output logic write_suppressed
);
   localparam int RAM_AW = $clog2(RAM_WORDS);
   localparam int SFR_AW = $clog2(SFR_WORDS);
   localparam logic [15:0] RAM_END = 16'(32'(RAM_BASE) + 2 * RAM_WORDS - 1);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] pick_ea(input mmd_src_t src, input logic [15:0] ptr,
                                           input logic [15:0] dir, input logic [12:0] nr);
      logic [15:0] ea;
      ea = ptr;
      if (src == SRC_DIRECT) begin
         ea = dir;
      end else if (src == SRC_NEAR) begin
         ea = {3'h0, nr};
      end
      return ea;
   endfunction

   function automatic mmd_region_t classify(input logic [15:0] ea);
      mmd_region_t rg;
      rg = RG_ZERO;
      if (ea[PSV_BIT]) begin
         rg = RG_PSV;
      end else if (ea <= SFR_END) begin
         rg = RG_SFR;
      end else if (ea >= RAM_BASE && ea <= RAM_END) begin
         rg = RG_RAM;
      end
      return rg;
   endfunction

   function automatic logic [RAM_AW-1:0] ram_index(input logic [15:0] ea);
      logic [15:0] off;
      off = ea - RAM_BASE;
      return off[RAM_AW:1];
   endfunction

   function automatic logic [15:0] lane_pick(input logic [15:0] w, input logic bsel,
                                             input logic hi);
      logic [15:0] r;
      r = w;
      if (bsel) begin
         r = {8'h00, hi ? w[15:8] : w[7:0]};
      end
      return r;
   endfunction

   // ****************************************
   // program counter and fetch
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         pc <= RESET_VECTOR;
      end else begin
         unique case (pc_op)
            PC_HOLD: pc <= pc;
            PC_FWD: pc <= pc + PC_STEP;
            PC_BACK: pc <= pc - PC_STEP;
            PC_JUMP: pc <= {pc_target[23:1], 1'b0};
         endcase
      end
   end

   // upper byte of the odd word has no storage behind it
   always_ff @(posedge mclk) begin
      if (reset) begin
         instr_word <= '0;
         pc_in_vectors <= 1'b1;
      end else begin
         instr_word <= {pm_hi_word[7:0], pm_lo_word};
         pc_in_vectors <= (pc < USER_CODE_BASE);
      end
   end

   // out-of-range vector numbers are dropped rather than spilling past the table
   always_ff @(posedge mclk) begin
      if (reset) begin
         vec_addr <= START_ADDR_LOC;
         vec_valid <= 1'b0;
      end else begin
         vec_valid <= vec_req && (vec_num < IVT_ENTRIES);
         if (vec_req && (vec_num < IVT_ENTRIES)) begin
            vec_addr <= (vec_alt ? (AIVT_BASE + IVT_BASE) : IVT_BASE)
                        + {16'h0000, vec_num, 1'b0};
         end
      end
   end

   // ****************************************
   // address generation
   // ****************************************
   logic [15:0] xr_ea, xw_ea;
   logic [15:0] xr_np, yr_np, xw_np;
   mmd_region_t xr_rg, yr_rg, xw_rg;
   logic xr_mis, xw_mis;
   logic ram_we_lo, ram_we_hi;

   assign xr_ea = pick_ea(xr_src, xr_ptr, xr_direct, xr_near);
   assign xw_ea = pick_ea(xw_src, xw_ptr, xw_direct, xw_near);

   mmd_agu #(.ALLOW_BITREV(1'b0)) u_agu_xr (
      .ptr(xr_ptr), .byte_op(xr_byte), .mode(xr_mode), .mod_start(mod_start),
      .mod_end(mod_end), .rev_mod(rev_mod), .next_ptr(xr_np)
   );
   mmd_agu #(.ALLOW_BITREV(1'b0)) u_agu_yr (
      .ptr(yr_ptr), .byte_op(1'b0), .mode(yr_mode), .mod_start(mod_start),
      .mod_end(mod_end), .rev_mod(rev_mod), .next_ptr(yr_np)
   );
   mmd_agu #(.ALLOW_BITREV(1'b1)) u_agu_xw (
      .ptr(xw_ptr), .byte_op(xw_byte), .mode(xw_mode), .mod_start(mod_start),
      .mod_end(mod_end), .rev_mod(rev_mod), .next_ptr(xw_np)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         xr_next_ptr <= WORD_RESET;
         yr_next_ptr <= WORD_RESET;
         xw_next_ptr <= WORD_RESET;
      end else begin
         if (xr_valid && xr_src == SRC_INDIRECT) begin
            xr_next_ptr <= xr_np;
         end
         if (yr_valid) begin
            yr_next_ptr <= yr_np;
         end
         if (xw_valid && xw_src == SRC_INDIRECT) begin
            xw_next_ptr <= xw_np;
         end
      end
   end

   assign xr_rg = classify(xr_ea);
   assign xw_rg = classify(xw_ea);
   // Y generator sees only its own slice; the boundary is a fixed parameter
   assign yr_rg = (yr_ptr >= Y_BASE && yr_ptr <= RAM_END) ? RG_RAM : RG_ZERO;
   assign xr_mis = xr_valid && !xr_byte && xr_ea[0];
   assign xw_mis = xw_valid && !xw_byte && xw_ea[0];

   // ****************************************
   // alignment check
   // ****************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_error <= 1'b0;
         write_suppressed <= 1'b0;
      end else begin
         addr_error <= xr_mis || xw_mis || (yr_valid && yr_ptr[0]);
         write_suppressed <= xw_mis;
      end
   end

   // ****************************************
   // write path: byte lanes, special registers
   // ****************************************
   logic [7:0] sfr_lo [SFR_WORDS];
   logic [7:0] sfr_hi [SFR_WORDS];
   logic sfr_hit;
   logic [SFR_AW-1:0] xw_sfr;

   assign xw_sfr = xw_ea[SFR_AW:1];
   assign sfr_hit = xw_valid && !xw_mis && xw_rg == RG_SFR && xw_ea[10:1] < SFR_WORDS;
   // misaligned words and window writes never reach the arrays
   assign ram_we_lo = xw_valid && !xw_mis && xw_rg == RG_RAM && (!xw_byte || !xw_ea[0]);
   assign ram_we_hi = xw_valid && !xw_mis && xw_rg == RG_RAM && (!xw_byte || xw_ea[0]);

   // working-register ops land after the bus write in the same cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < SFR_WORDS; i++) begin
            sfr_lo[i] <= 8'h00;
            sfr_hi[i] <= 8'h00;
         end
      end else begin
         if (sfr_hit && (!xw_byte || !xw_ea[0])) begin
            sfr_lo[xw_sfr] <= xw_data[7:0];
         end
         if (sfr_hit && (!xw_byte || xw_ea[0])) begin
            sfr_hi[xw_sfr] <= xw_byte ? xw_data[7:0] : xw_data[15:8];
         end
         unique case (w_op)
            WOP_NONE: ;
            WOP_LOAD: sfr_lo[w_sel] <= w_byte;
            WOP_SIGN_EXT: sfr_hi[w_sel] <= {8{sfr_lo[w_sel][7]}};
            WOP_ZERO_EXT: sfr_hi[w_sel] <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // read path, two stages
   // ****************************************
   logic [15:0] ram_x, ram_y;
   logic [15:0] xw_wide;
   mmd_region_t xr_rg_q, yr_rg_q;
   logic xr_v_q, yr_v_q, xr_byte_q, xr_hi_q;
   logic [15:0] sfr_q;

   // a byte write carries its byte on both lanes; the strobe picks one
   assign xw_wide = xw_byte ? {xw_data[7:0], xw_data[7:0]} : xw_data;

   mmd_lane_ram #(.DEPTH(RAM_WORDS), .AW(RAM_AW)) u_ram (
      .mclk(mclk),
      .x_addr(ram_index(xr_ea)),
      .x_data(ram_x),
      .y_addr(ram_index(yr_ptr)),
      .y_data(ram_y),
      .w_addr(ram_index(xw_ea)),
      .we_lo(ram_we_lo),
      .we_hi(ram_we_hi),
      .w_data(xw_wide)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         xr_v_q <= 1'b0;
         yr_v_q <= 1'b0;
         xr_rg_q <= RG_ZERO;
         yr_rg_q <= RG_ZERO;
         xr_byte_q <= 1'b0;
         xr_hi_q <= 1'b0;
         sfr_q <= WORD_RESET;
         xr_psv <= 1'b0;
         psv_ea <= WORD_RESET;
      end else begin
         xr_v_q <= xr_valid;
         yr_v_q <= yr_valid;
         xr_rg_q <= xr_rg;
         yr_rg_q <= yr_rg;
         xr_byte_q <= xr_byte;
         xr_hi_q <= xr_ea[0];
         // unused register slots read back as zero
         sfr_q <= (xr_ea[10:1] < SFR_WORDS) ?
                  {sfr_hi[xr_ea[SFR_AW:1]], sfr_lo[xr_ea[SFR_AW:1]]} : WORD_RESET;
         xr_psv <= xr_valid && xr_rg == RG_PSV;
         if (xr_valid && xr_rg == RG_PSV) begin
            psv_ea <= xr_ea;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         xr_rdata <= WORD_RESET;
         xr_rvalid <= 1'b0;
         yr_rdata <= WORD_RESET;
         yr_rvalid <= 1'b0;
      end else begin
         xr_rvalid <= xr_v_q;
         yr_rvalid <= yr_v_q;
         unique case (xr_rg_q)
            RG_SFR: xr_rdata <= lane_pick(sfr_q, xr_byte_q, xr_hi_q);
            RG_RAM: xr_rdata <= lane_pick(ram_x, xr_byte_q, xr_hi_q);
            RG_ZERO, RG_PSV: xr_rdata <= WORD_RESET;
         endcase
         yr_rdata <= (yr_rg_q == RG_RAM) ? ram_y : WORD_RESET;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_pc_reset;
      @(posedge mclk) $past(reset) |-> pc == RESET_VECTOR;
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("pc not at reset vector");

   property p_pc_step;
      @(posedge mclk) disable iff (reset) pc_op == PC_FWD |=> pc == $past(pc) + PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step by two");

   property p_pc_even;
      @(posedge mclk) disable iff (reset) pc[0] == 1'b0;
   endproperty
   a_pc_even: assert property (p_pc_even) else $error("pc left the lower word");

   property p_mis_err;
      @(posedge mclk) disable iff (reset) xr_valid && !xr_byte && xr_ea[0] |=> addr_error;
   endproperty
   a_mis_err: assert property (p_mis_err) else $error("misaligned read not flagged");

   property p_no_err;
      @(posedge mclk) disable iff (reset)
         !xr_mis && !xw_mis && !(yr_valid && yr_ptr[0]) |=> !addr_error;
   endproperty
   a_no_err: assert property (p_no_err) else $error("spurious address error");

   property p_wr_supp;
      @(posedge mclk) disable iff (reset)
         xw_valid && !xw_byte && xw_ea[0] |-> !ram_we_lo && !ram_we_hi && !sfr_hit;
   endproperty
   a_wr_supp: assert property (p_wr_supp) else $error("misaligned write reached memory");

   property p_lane;
      @(posedge mclk) disable iff (reset)
         xw_valid && xw_byte && xw_rg == RG_RAM |-> ram_we_lo != ram_we_hi;
   endproperty
   a_lane: assert property (p_lane) else $error("byte write hit both lanes");

   property p_zero_read;
      @(posedge mclk) disable iff (reset)
         xr_valid && xr_rg == RG_ZERO |-> ##2 xr_rvalid && xr_rdata == 16'h0000;
   endproperty
   a_zero_read: assert property (p_zero_read) else $error("unimplemented read not zero");

   property p_byte_read;
      @(posedge mclk) disable iff (reset) xr_valid && xr_byte |-> ##2 xr_rdata[15:8] == 8'h00;
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("byte read upper lane not clear");

   property p_psv;
      @(posedge mclk) disable iff (reset)
         xr_valid && xr_ea[15] |=> xr_psv && psv_ea == $past(xr_ea);
   endproperty
   a_psv: assert property (p_psv) else $error("window access not routed");

   property p_inc;
      @(posedge mclk) disable iff (reset)
         xr_valid && xr_src == SRC_INDIRECT && xr_mode == AM_POSTINC && xr_byte
         |=> xr_next_ptr == $past(xr_ptr) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("byte post-increment not one");

   property p_wload;
      @(posedge mclk) disable iff (reset)
         w_op == WOP_LOAD && !(xw_valid && xw_rg == RG_SFR)
         |=> sfr_hi[$past(w_sel)] == $past(sfr_hi[w_sel]) && sfr_lo[$past(w_sel)] == $past(w_byte);
   endproperty
   a_wload: assert property (p_wload) else $error("byte load disturbed high byte");

   c_byte_read: cover property (@(posedge mclk) disable iff (reset) xr_valid && xr_byte && xr_ea[0]);
   c_mis_write: cover property (@(posedge mclk) disable iff (reset) xw_mis);
   c_psv: cover property (@(posedge mclk) disable iff (reset) xr_psv);
   c_dual: cover property (@(posedge mclk) disable iff (reset) xr_rvalid && yr_rvalid);
endmodule

// ==== mmd_core_tb.sv ====
`timescale 1ns/10ps
module mmd_core_tb;
   import mmd_pkg::*;
   // ****************************************
   // stimulus and design
   // ****************************************
   logic mclk, reset, vec_req, vec_alt, pc_in_vectors, vec_valid, xr_valid, xr_byte, xw_valid;
   logic xr_rvalid, yr_rvalid, xr_psv, addr_error, write_suppressed, ae, ws, ps, yr_valid;
   logic [23:0] pc_target, pc, instr_word, vec_addr;
   logic [15:0] pm_lo_word, pm_hi_word, xr_rdata, yr_rdata, xr_next_ptr, yr_next_ptr;
   logic [15:0] xw_next_ptr, psv_ea, xr_ptr, xr_direct, xw_data, rd, yr_ptr;
   logic [12:0] xr_near;
   logic [6:0] vec_num;
   logic [7:0] w_byte;
   logic [3:0] w_sel;
   mmd_pcop_t pc_op;
   mmd_amode_t xr_mode;
   mmd_src_t xr_src;
   mmd_wop_t w_op;
   int failures, check_count;

   mmd_pmem_model pm (.pc, .pm_lo_word, .pm_hi_word);
   // write port shares the read port's address fields; the valids pick the side
   mmd_core #(.RAM_WORDS(256), .Y_BASE(16'h0900)) uut (
      .mclk, .reset, .pc_op, .pc_target, .pm_lo_word, .pm_hi_word, .vec_req, .vec_alt,
      .vec_num, .pc, .instr_word, .pc_in_vectors, .vec_addr, .vec_valid, .xr_valid,
      .xr_byte, .xr_src, .xr_mode, .xr_ptr, .xr_direct, .xr_near, .yr_valid,
      .yr_mode(xr_mode), .yr_ptr, .xw_valid, .xw_byte(xr_byte), .xw_src(xr_src),
      .xw_mode(xr_mode), .xw_ptr(xr_ptr), .xw_direct(xr_direct), .xw_near(xr_near),
      .xw_data, .mod_start(16'h0800), .mod_end(16'h0803), .rev_mod(16'h0008), .w_op,
      .w_sel, .w_byte, .xr_rdata, .xr_rvalid, .yr_rdata, .yr_rvalid, .xr_next_ptr,
      .yr_next_ptr, .xw_next_ptr, .xr_psv, .psv_ea, .addr_error, .write_suppressed);

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // one data access; flags are gathered over the answer window
   task automatic acc(input logic wr, input logic bt, input mmd_src_t s,
                      input logic [15:0] ea, input logic [15:0] d);
      rd = 16'hXXXX;
      {ae, ws, ps} = 3'b000;
      @(posedge mclk);
      xr_valid <= !wr;
      xw_valid <= wr;
      xr_byte <= bt;
      xr_src <= s;
      xr_ptr <= ea;
      xr_direct <= ea;
      xr_near <= ea[12:0];
      xw_data <= d;
      @(posedge mclk);
      xr_valid <= 1'b0;
      xw_valid <= 1'b0;
      repeat (4) begin
         #1;
         ae |= addr_error;
         ws |= write_suppressed;
         ps |= xr_psv;
         if (xr_rvalid === 1'b1) rd = xr_rdata;
         @(posedge mclk);
      end
   endtask

   task automatic pst(input mmd_pcop_t op, input logic [23:0] t, input logic [23:0] e);
      logic [23:0] p;
      p = pc;
      @(posedge mclk);
      pc_op <= op;
      pc_target <= t;
      @(posedge mclk);
      pc_op <= PC_HOLD;
      #1;
      chk("pc", e, pc);
      chk("instr_word", {p[7:0] ^ 8'h3C, p[15:0] ^ 16'h5A5A}, instr_word);
   endtask

   task automatic vec(input logic a, input logic [6:0] n, input logic v, input logic [23:0] e);
      logic seen;
      seen = 1'b0;
      @(posedge mclk);
      vec_req <= 1'b1;
      vec_alt <= a;
      vec_num <= n;
      @(posedge mclk);
      vec_req <= 1'b0;
      repeat (3) begin
         #1;
         if (vec_valid === 1'b1) seen = 1'b1;
         @(posedge mclk);
      end
      chk("vec_valid", {23'h0, v}, {23'h0, seen});
      if (v) chk("vec_addr", e, vec_addr);
   endtask

   task automatic wop(input mmd_wop_t op, input logic [7:0] b);
      @(posedge mclk);
      w_op <= op;
      w_sel <= 4'h1;
      w_byte <= b;
      @(posedge mclk);
      w_op <= WOP_NONE;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_prog;
      chk("pc", 24'h000000, pc);
      chk("vec_addr", 24'h000002, vec_addr);
      chk("in_vec", 24'h000001, {23'h0, pc_in_vectors});
      pst(PC_FWD, 24'h000000, 24'h000002);
      pst(PC_FWD, 24'h000000, 24'h000004);
      pst(PC_BACK, 24'h000000, 24'h000002);
      pst(PC_JUMP, 24'h000201, 24'h000200);
      repeat (2) @(posedge mclk);
      #1;
      chk("in_vec", 24'h000000, {23'h0, pc_in_vectors});
      $display("program test done");
   endtask

   task automatic t_vec;
      vec(1'b0, 7'h03, 1'b1, 24'h00000A);
      vec(1'b0, 7'h7D, 1'b1, 24'h0000FE);
      vec(1'b1, 7'h00, 1'b1, 24'h000104);
      vec(1'b1, 7'h7D, 1'b1, 24'h0001FE);
      vec(1'b0, 7'h7E, 1'b0, 24'h000000);
      $display("vector test done");
   endtask

   task automatic t_data;
      acc(1'b1, 1'b0, SRC_INDIRECT, 16'h0800, 16'hBEEF);
      acc(1'b1, 1'b0, SRC_DIRECT, 16'h0802, 16'h1122);
      acc(1'b1, 1'b1, SRC_DIRECT, 16'h0803, 16'h0077);
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0802, 16'h0000);
      chk("lanes", 24'h007722, {8'h0, rd});
      acc(1'b0, 1'b1, SRC_INDIRECT, 16'h0801, 16'h0000);
      chk("hi_byte", 24'h0000BE, {8'h0, rd});
      chk("next_b", 24'h000802, {8'h0, xr_next_ptr});
      acc(1'b0, 1'b1, SRC_INDIRECT, 16'h0800, 16'h0000);
      chk("lo_byte", 24'h0000EF, {8'h0, rd});
      acc(1'b0, 1'b0, SRC_INDIRECT, 16'h0800, 16'h0000);
      chk("next_w", 24'h000802, {8'h0, xr_next_ptr});
      chk("ae_ok", 24'h000000, {23'h0, ae});
      acc(1'b1, 1'b0, SRC_DIRECT, 16'h0803, 16'hFFFF);
      chk("ae_wr", 24'h000003, {22'h0, ae, ws});
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0802, 16'h0000);
      chk("no_write", 24'h007722, {8'h0, rd});
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0801, 16'h0000);
      chk("ae_rd", 24'h01BEEF, {7'h0, ae, rd});
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0A00, 16'h0000);
      chk("unimpl", 24'h000000, {8'h0, rd});
      acc(1'b0, 1'b0, SRC_INDIRECT, 16'h8000, 16'h0000);
      chk("window", 24'h010000, {7'h0, ps, rd});
      chk("psv_ea", 24'h008000, {8'h0, psv_ea});
      $display("data test done");
   endtask

   task automatic t_wreg;
      acc(1'b1, 1'b0, SRC_NEAR, 16'h0002, 16'h1234);
      wop(WOP_LOAD, 8'hA5);
      acc(1'b0, 1'b0, SRC_NEAR, 16'h0002, 16'h0000);
      chk("load", 24'h0012A5, {8'h0, rd});
      wop(WOP_SIGN_EXT, 8'h00);
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0002, 16'h0000);
      chk("sext", 24'h00FFA5, {8'h0, rd});
      wop(WOP_ZERO_EXT, 8'h00);
      acc(1'b0, 1'b0, SRC_INDIRECT, 16'h0002, 16'h0000);
      chk("zext", 24'h0000A5, {8'h0, rd});
      acc(1'b0, 1'b0, SRC_NEAR, 16'h0442, 16'h0000);
      chk("unused", 24'h000000, {8'h0, rd});
      $display("register test done");
   endtask

   task automatic t_ptr;
      xr_mode <= AM_MODULO;
      acc(1'b0, 1'b0, SRC_INDIRECT, 16'h0802, 16'h0000);
      chk("modulo", 24'h000800, {8'h0, xr_next_ptr});
      xr_mode <= AM_BITREV;
      acc(1'b1, 1'b0, SRC_INDIRECT, 16'h0808, 16'h0000);
      chk("bitrev_w", 24'h000804, {8'h0, xw_next_ptr});
      acc(1'b0, 1'b0, SRC_INDIRECT, 16'h0808, 16'h0000);
      chk("bitrev_r", 24'h00080A, {8'h0, xr_next_ptr});
      xr_mode <= AM_POSTDEC;
      acc(1'b0, 1'b1, SRC_INDIRECT, 16'h0805, 16'h0000);
      chk("dec_b", 24'h000804, {8'h0, xr_next_ptr});
      xr_mode <= AM_POSTINC;
      $display("pointer test done");
   endtask

   task automatic t_dual;
      acc(1'b1, 1'b0, SRC_DIRECT, 16'h0900, 16'hCAFE);
      yr_ptr <= 16'h0900;
      yr_valid <= 1'b1;
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0800, 16'h0000);
      #1;
      chk("dual", 24'h01CAFE, {7'h0, yr_rvalid, yr_rdata});
      chk("y_next", 24'h000902, {8'h0, yr_next_ptr});
      @(posedge mclk);
      yr_ptr <= 16'h0803;
      acc(1'b0, 1'b0, SRC_DIRECT, 16'h0800, 16'h0000);
      #1;
      chk("y_out", 24'h010000, {7'h0, ae, yr_rdata});
      @(posedge mclk);
      yr_valid <= 1'b0;
      $display("dual test done");
   endtask

   initial begin
      {reset, vec_req, vec_alt, xr_valid, xr_byte, xw_valid, yr_valid} = 7'b1000000;
      {pc_target, xr_ptr, xr_direct, xw_data, yr_ptr} = 88'h0;
      {xr_near, vec_num, w_byte, w_sel} = 32'h0;
      pc_op = PC_HOLD;
      xr_mode = AM_POSTINC;
      xr_src = SRC_INDIRECT;
      w_op = WOP_NONE;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      t_prog();
      t_vec();
      t_data();
      t_wreg();
      t_ptr();
      t_dual();
      end_sim();
   end

   initial begin
      #40000;
      failures++;
      end_sim();
   end
endmodule

// ==== mmd_lane_ram.sv ====
`timescale 1ns/10ps
module mmd_lane_ram #(
   parameter int DEPTH = 15360,
   parameter int AW = 14
) (
   input wire logic mclk,
   input wire logic [AW-1:0] x_addr,
   output logic [15:0] x_data,
   input wire logic [AW-1:0] y_addr,
   output logic [15:0] y_data,
   input wire logic [AW-1:0] w_addr,
   input wire logic we_lo,
   input wire logic we_hi,
   input wire logic [15:0] w_data
);
   // ****************************************
   // two byte lanes, one word decode
   // ****************************************
   logic [7:0] lane_lo [DEPTH];
   logic [7:0] lane_hi [DEPTH];

   always_ff @(posedge mclk) begin
      if (we_lo) begin
         lane_lo[w_addr] <= w_data[7:0];
      end
      if (we_hi) begin
         lane_hi[w_addr] <= w_data[15:8];
      end
   end

   always_ff @(posedge mclk) begin
      x_data <= {lane_hi[x_addr], lane_lo[x_addr]};
      y_data <= {lane_hi[y_addr], lane_lo[y_addr]};
   end
endmodule

// ==== mmd_pkg.sv ====
// Overview of operation
// - program location is 24 bits: even lower word, odd upper word, top byte unused
// - program counter stays on the lower word and steps by two
// - program addresses below 0x000200 hold fixed vectors, not user code
// - reset starts at 0x000000; the start address sits at 0x000002
// - primary vector table 0x000004-0x0000FF, alternate table 0x000100-0x0001FF
// - data addresses are 16-bit byte addresses over 64 Kbytes
// - address bit 15 clear goes to data memory, set goes to visibility window
// - data memory is at most 30 Kbytes; reads outside it return zero
// - low byte of a word sits at the even address, high byte at odd
// - post-increment adds 1 for byte and 2 for word operations
// - byte read fetches the word and returns the chosen byte on the low lane
// - two byte lanes share word decode; byte writes strobe only their lane
// - word access at an odd address raises an address error trap
// - misaligned read completes; misaligned write executes but memory is untouched
// - byte load into a working register leaves its high byte unchanged
// - sign-extend widens signed byte to 16 bits; zero-extend clears the upper byte
// - data 0x0000-0x07FF holds special function registers; unused ones read zero
// - data 0x0000-0x1FFF is the near region reached by a 13-bit field
// - whole data space reachable by 16-bit direct field or register pointer
// - X and Y regions have own address generators and paths for dual reads
// - X has separate read and write buses; X read serves combined-space reads
// - modulo addressing in X and Y; bit-reversed only for X writes
// - all writes use the combined space; X/Y boundary is fixed per device
package mmd_pkg;
   // ****************************************
   // program space
   // ****************************************
   localparam int PROG_AW = 24;
   localparam logic [23:0] PC_STEP = 24'h000002;
   localparam logic [23:0] RESET_VECTOR = 24'h000000;
   localparam logic [23:0] START_ADDR_LOC = 24'h000002;
   localparam logic [23:0] IVT_BASE = 24'h000004;
   localparam logic [23:0] IVT_END = 24'h0000FF;
   localparam logic [23:0] AIVT_BASE = 24'h000100;
   localparam logic [23:0] AIVT_END = 24'h0001FF;
   localparam logic [23:0] USER_CODE_BASE = 24'h000200;
   localparam logic [6:0] IVT_ENTRIES = 7'h7E;
   localparam int INSTR_W = 24;
   // ****************************************
   // data space
   // ****************************************
   localparam int EA_W = 16;
   localparam int PSV_BIT = 15;
   localparam logic [15:0] SFR_END = 16'h07FF;
   localparam logic [15:0] NEAR_END = 16'h1FFF;
   localparam int NEAR_W = 13;
   localparam logic [15:0] RAM_BASE = 16'h0800;
   localparam int RAM_MAX_BYTES = 30720;
   localparam int RAM_WORDS_DEF = RAM_MAX_BYTES / 2;
   localparam logic [15:0] Y_BASE_DEF = 16'h4800;
   localparam logic [15:0] INC_BYTE = 16'h0001;
   localparam logic [15:0] INC_WORD = 16'h0002;
   localparam int SFR_WORDS_DEF = 32;
   localparam int WREG_COUNT = 16;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam int RD_LATENCY = 2;

   typedef enum logic [2:0] {AM_PLAIN, AM_POSTINC, AM_POSTDEC, AM_MODULO, AM_BITREV} mmd_amode_t;
   typedef enum logic [1:0] {SRC_INDIRECT, SRC_DIRECT, SRC_NEAR} mmd_src_t;
   typedef enum logic [1:0] {WOP_NONE, WOP_LOAD, WOP_SIGN_EXT, WOP_ZERO_EXT} mmd_wop_t;
   typedef enum logic [2:0] {PC_HOLD, PC_FWD, PC_BACK, PC_JUMP} mmd_pcop_t;
   typedef enum logic [1:0] {RG_ZERO, RG_SFR, RG_RAM, RG_PSV} mmd_region_t;
endpackage

// ==== mmd_pmem_model.sv ====
`timescale 1ns/10ps
module mmd_pmem_model (
   input wire logic [23:0] pc,
   output logic [15:0] pm_lo_word,
   output logic [15:0] pm_hi_word
);
   // upper byte driven non-zero so a design that keeps it is caught
   assign pm_lo_word = pc[15:0] ^ 16'h5A5A;
   assign pm_hi_word = {8'hC3, pc[7:0] ^ 8'h3C};
endmodule
